// ### rtl/hw_loop_from_register.sv
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "hw_loop_params.svh"

// Function
// - Count takes source register bits 13..0 only
// - Start is PC+4, end start plus 2*offset
// - Setup increments nest level, sets active flag
// - Decode two words: opcode+select, then offset
// - Save context to shadow, restore on completion
// - Body runs count plus one times
module hw_loop_from_register #(
  parameter int PC_W = 23
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            issue_valid,
  input  wire logic [23:0]     issue_word,
  input  wire logic [PC_W-1:0] issue_pc,
  input  wire logic [15:0]     work_reg_rdata,
  input  wire logic            fetch_valid,
  input  wire logic [PC_W-1:0] fetch_pc,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_we,
  input  wire logic            reg_re,
  output logic      [31:0]     reg_rdata,
  output logic      [3:0]      work_reg_sel_q,
  output logic                 pc_load_q,
  output logic      [PC_W-1:0] pc_load_addr_q,
  output logic                 loop_active_flag_q,
  output logic      [2:0]      loop_nest_level_q
);

  localparam int CW = `HWL_COUNT_MSB + 1;

  initial begin
    if (PC_W < 17 || PC_W > 32) begin
      $error("PC_W must be 17..32");
    end
  end

  // ************************************************************
  // Decode
  // ************************************************************
  hw_loop_pkg::seq_state_e state_q;
  logic [PC_W-1:0]         first_pc_q;
  logic [CW-1:0]           loop_count_reg_q;
  logic [PC_W-1:0]         loop_start_addr_q;
  logic [PC_W-1:0]         loop_end_addr_q;
  logic [15:0]             ctl_other_q;
  logic [CW-1:0]           sh_count;
  logic [PC_W-1:0]         sh_start;
  logic [PC_W-1:0]         sh_end;
  logic                    first_hit;
  logic                    second_hit;
  logic                    setup_fire;
  logic                    end_hit;
  logic                    loop_done;
  logic [PC_W-1:0]         new_start;
  logic [PC_W-1:0]         new_end;
  logic [PC_W-1:0]         ofs_x2;

  assign first_hit  = issue_valid
                    && ((issue_word & `HWL_OP_MASK) == `HWL_OP_MATCH);
  assign second_hit = issue_valid
                    && ((issue_word & `HWL_W2_MASK) == 24'h000000);
  assign setup_fire = (state_q == hw_loop_pkg::ST_OFFSET) && second_hit;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= hw_loop_pkg::ST_IDLE;
    end else begin
      case (state_q)
        hw_loop_pkg::ST_IDLE: begin
          if (first_hit) begin
            state_q <= hw_loop_pkg::ST_OFFSET;
          end
        end
        hw_loop_pkg::ST_OFFSET: begin
          // Only a matching offset word completes the pair
          if (issue_valid) begin
            state_q <= hw_loop_pkg::ST_IDLE;
          end
        end
        default: state_q <= hw_loop_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      work_reg_sel_q <= 4'h0;
      first_pc_q     <= '0;
    end else if (state_q == hw_loop_pkg::ST_IDLE && first_hit) begin
      work_reg_sel_q <= issue_word[3:0];
      first_pc_q     <= issue_pc;
    end
  end

  // ************************************************************
  // Address arithmetic
  // ************************************************************
  // Offset counts instruction words; one word spans two PC units
  assign ofs_x2    = PC_W'({{(PC_W-17){issue_word[15]}}, issue_word[15:0], 1'b0});
  assign new_start = first_pc_q + PC_W'(`HWL_PC_STEP);
  assign new_end   = new_start + ofs_x2;

  // ************************************************************
  // Loop end detection
  // ************************************************************
  // Caller keeps flow changes out of the loop tail, so the fetch
  // of the end address is always the body's last instruction
  assign end_hit   = fetch_valid && loop_active_flag_q
                   && (fetch_pc == loop_end_addr_q) && !setup_fire;
  assign loop_done = end_hit && (loop_count_reg_q == '0);

  // ************************************************************
  // Loop context
  // ************************************************************
  loop_ctx_shadow #(
    .CW (CW),
    .AW (PC_W)
  ) u_shadow (
    .clk      (clk),
    .rst      (rst),
    .push     (setup_fire),
    .in_count (loop_count_reg_q),
    .in_start (loop_start_addr_q),
    .in_end   (loop_end_addr_q),
    .count_q  (sh_count),
    .start_q  (sh_start),
    .end_q    (sh_end)
  );

  // Hardware updates win over a register write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      loop_count_reg_q <= `HWL_COUNT_RST;
    end else if (setup_fire) begin
      loop_count_reg_q <= work_reg_rdata[`HWL_COUNT_MSB:0];
    end else if (loop_done) begin
      loop_count_reg_q <= sh_count;
    end else if (end_hit) begin
      loop_count_reg_q <= loop_count_reg_q - CW'(1);
    end else if (reg_we && reg_addr == `HWL_ADDR_COUNT) begin
      loop_count_reg_q <= reg_wdata[CW-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      loop_start_addr_q <= '0;
      loop_end_addr_q   <= '0;
    end else if (setup_fire) begin
      loop_start_addr_q <= new_start;
      loop_end_addr_q   <= new_end;
    end else if (loop_done) begin
      loop_start_addr_q <= sh_start;
      loop_end_addr_q   <= sh_end;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      loop_nest_level_q  <= `HWL_LEVEL_RST;
      loop_active_flag_q <= 1'b0;
    end else if (setup_fire) begin
      loop_nest_level_q  <= loop_nest_level_q + 3'h1;
      loop_active_flag_q <= 1'b1;
    end else if (loop_done) begin
      loop_nest_level_q  <= loop_nest_level_q - 3'h1;
      loop_active_flag_q <= (loop_nest_level_q > 3'h1);
    end
  end

  // ************************************************************
  // Program counter redirect
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_load_q      <= 1'b0;
      pc_load_addr_q <= '0;
    end else if (setup_fire) begin
      pc_load_q      <= 1'b1;
      pc_load_addr_q <= new_start;
    end else if (end_hit && !loop_done) begin
      pc_load_q      <= 1'b1;
      pc_load_addr_q <= loop_start_addr_q;
    end else begin
      pc_load_q      <= 1'b0;
    end
  end

  // ************************************************************
  // Register port
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_other_q <= `HWL_CTL_RST;
    end else if (reg_we && reg_addr == `HWL_ADDR_CORE_CTL) begin
      ctl_other_q <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_re) begin
      if (reg_addr == `HWL_ADDR_CORE_CTL) begin
        reg_rdata <= {16'h0000, ctl_other_q[15:`HWL_LEVEL_MSB+1],
                      loop_nest_level_q, ctl_other_q[`HWL_LEVEL_LSB-1:0]};
      end else if (reg_addr == `HWL_ADDR_STATUS) begin
        reg_rdata <= 32'(loop_active_flag_q) << `HWL_ACTIVE_BIT;
      end else if (reg_addr == `HWL_ADDR_COUNT) begin
        reg_rdata <= 32'(loop_count_reg_q);
      end else if (reg_addr == `HWL_ADDR_START) begin
        reg_rdata <= 32'(loop_start_addr_q);
      end else if (reg_addr == `HWL_ADDR_END) begin
        reg_rdata <= 32'(loop_end_addr_q);
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_first_word;
    (state_q == hw_loop_pkg::ST_IDLE) && first_hit;
  endsequence

  sequence s_offset_word;
    second_hit;
  endsequence

  property p_decode_pair;
    @(posedge clk) disable iff (rst)
      s_first_word ##1 s_offset_word |=> pc_load_q && loop_active_flag_q;
  endproperty
  a_decode_pair: assert property (p_decode_pair)
    else $error("Instruction pair did not start a loop");

  property p_count_low_bits;
    @(posedge clk) disable iff (rst)
      setup_fire |=> loop_count_reg_q == $past(work_reg_rdata[13:0]);
  endproperty
  a_count_low_bits: assert property (p_count_low_bits)
    else $error("Loop count not taken from low 14 bits");

  property p_start_end;
    @(posedge clk) disable iff (rst)
      s_first_word ##1 (s_offset_word and setup_fire)
      |=> loop_start_addr_q == $past(first_pc_q) + PC_W'(4)
          && loop_end_addr_q == $past(new_end)
          && pc_load_addr_q == loop_start_addr_q;
  endproperty
  a_start_end: assert property (p_start_end)
    else $error("Loop start or end address wrong");

  property p_level_up;
    @(posedge clk) disable iff (rst)
      setup_fire |=> loop_nest_level_q == $past(loop_nest_level_q) + 3'h1
                     && loop_active_flag_q;
  endproperty
  a_level_up: assert property (p_level_up)
    else $error("Nest level or active flag not raised");

  property p_shadow_save;
    @(posedge clk) disable iff (rst)
      setup_fire |=> sh_count == $past(loop_count_reg_q)
                     && sh_end == $past(loop_end_addr_q);
  endproperty
  a_shadow_save: assert property (p_shadow_save)
    else $error("Loop context not saved");

  property p_last_pass;
    @(posedge clk) disable iff (rst)
      end_hit && loop_count_reg_q == '0
      |=> !pc_load_q && loop_end_addr_q == $past(sh_end);
  endproperty
  a_last_pass: assert property (p_last_pass)
    else $error("Loop repeated after count reached zero");

  property p_loop_exit;
    @(posedge clk) disable iff (rst)
      loop_done |=> loop_nest_level_q == $past(loop_nest_level_q) - 3'h1
                    && loop_active_flag_q == (loop_nest_level_q != 3'h0);
  endproperty
  a_loop_exit: assert property (p_loop_exit)
    else $error("Nest level or active flag wrong at loop end");

endmodule

// ### rtl/hw_loop_params.svh
`ifndef HW_LOOP_PARAMS_SVH
`define HW_LOOP_PARAMS_SVH

// Register offsets, byte addresses on the plain register port
`define HWL_ADDR_CORE_CTL 8'h00
`define HWL_ADDR_STATUS   8'h04
`define HWL_ADDR_COUNT    8'h08
`define HWL_ADDR_START    8'h0C
`define HWL_ADDR_END      8'h10

// Field positions
`define HWL_LEVEL_LSB  8
`define HWL_LEVEL_MSB  10
`define HWL_ACTIVE_BIT 7
`define HWL_COUNT_MSB  13

// Instruction decode
`define HWL_OP_MATCH   24'h088000
`define HWL_OP_MASK    24'hFFFFF0
`define HWL_W2_MASK    24'hFF0000
`define HWL_PC_STEP    4

// Reset values
`define HWL_COUNT_RST  14'h0000
`define HWL_LEVEL_RST  3'h0
`define HWL_CTL_RST    16'h0000

`endif

// ### rtl/hw_loop_pkg.sv
package hw_loop_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_OFFSET = 2'b10
  } seq_state_e;

endpackage

// ### rtl/loop_ctx_shadow.sv
`timescale 1ns/1ns
`include "hw_loop_params.svh"

// One level of saved loop context
module loop_ctx_shadow #(
  parameter int CW = 14,
  parameter int AW = 23
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          push,
  input  wire logic [CW-1:0] in_count,
  input  wire logic [AW-1:0] in_start,
  input  wire logic [AW-1:0] in_end,
  output logic      [CW-1:0] count_q,
  output logic      [AW-1:0] start_q,
  output logic      [AW-1:0] end_q
);

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
      start_q <= '0;
      end_q   <= '0;
    end else if (push) begin
      count_q <= in_count;
      start_q <= in_start;
      end_q   <= in_end;
    end
  end

endmodule

// ### tb/hw_loop_from_register_tb_top.sv
`timescale 1ns/1ns
`include "hw_loop_params.svh"

module hw_loop_from_register_tb_top;
  localparam int PC_W = 23;

  // ********************************************************
  // Signals and design
  // ********************************************************
  logic            clk             = 1'b0;
  logic            rst             = 1'b1;
  logic            issue_valid     = 1'b0;
  logic [23:0]     issue_word      = 24'h000000;
  logic [PC_W-1:0] issue_pc        = '0;
  logic [15:0]     work_reg_rdata;
  logic            fetch_valid     = 1'b0;
  logic [PC_W-1:0] fetch_pc        = '0;
  logic [7:0]      reg_addr        = 8'h00;
  logic [31:0]     reg_wdata       = 32'h00000000;
  logic            reg_we          = 1'b0;
  logic            reg_re          = 1'b0;
  logic [31:0]     reg_rdata;
  logic [3:0]      work_reg_sel_q;
  logic            pc_load_q;
  logic [PC_W-1:0] pc_load_addr_q;
  logic            loop_active_flag_q;
  logic [2:0]      loop_nest_level_q;
  logic [15:0]     wregs [16];
  int              mismatches      = 0;
  int              samples_checked = 0;

  always #4 clk = ~clk;

  // Upper bits set on purpose so a full-width load shows up
  initial begin
    for (int i = 0; i < 16; i++) begin
      wregs[i] = 16'h0000;
    end
    wregs[7] = 16'hE00F;
    wregs[2] = 16'hC000;
  end

  assign work_reg_rdata = wregs[work_reg_sel_q];

  hw_loop_from_register #(.PC_W(PC_W)) i_hw_loop_from_register (
    .clk                (clk),
    .rst                (rst),
    .issue_valid        (issue_valid),
    .issue_word         (issue_word),
    .issue_pc           (issue_pc),
    .work_reg_rdata     (work_reg_rdata),
    .fetch_valid        (fetch_valid),
    .fetch_pc           (fetch_pc),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_we             (reg_we),
    .reg_re             (reg_re),
    .reg_rdata          (reg_rdata),
    .work_reg_sel_q     (work_reg_sel_q),
    .pc_load_q          (pc_load_q),
    .pc_load_addr_q     (pc_load_addr_q),
    .loop_active_flag_q (loop_active_flag_q),
    .loop_nest_level_q  (loop_nest_level_q)
  );

  // ********************************************************
  // Tasks
  // ********************************************************
  task automatic finish_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clk);
    reg_re   <= 1'b0;
    @(negedge clk);
    check(reg_rdata, e);
  endtask

  // Redirect pulse is looked at in its one cycle only
  task automatic redirect(input logic ld, input logic [PC_W-1:0] ad);
    @(negedge clk);
    check({31'h0, pc_load_q}, {31'h0, ld});
    if (ld) begin
      check({9'h000, pc_load_addr_q}, {9'h000, ad});
    end
  endtask

  task automatic go(input logic [23:0] w1, input logic [PC_W-1:0] pc, input logic [23:0] w2,
                    input logic ld, input logic [PC_W-1:0] ad);
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_word  <= w1;
    issue_pc    <= pc;
    @(posedge clk);
    issue_word  <= w2;
    @(posedge clk);
    issue_valid <= 1'b0;
    redirect(ld, ad);
  endtask

  task automatic fet(input logic [PC_W-1:0] pc, input logic ld, input logic [PC_W-1:0] ad);
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_pc    <= pc;
    @(posedge clk);
    fetch_valid <= 1'b0;
    redirect(ld, ad);
  endtask

  task automatic st(input logic [2:0] lv, input logic f);
    check({29'h0, loop_nest_level_q}, {29'h0, lv});
    check({31'h0, loop_active_flag_q}, {31'h0, f});
  endtask

  // ********************************************************
  // Tests
  // ********************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(`HWL_ADDR_CORE_CTL, 32'h00000000);
    rd(`HWL_ADDR_STATUS, 32'h00000000);
    rd(`HWL_ADDR_COUNT, 32'h00000000);
    rd(8'h20, 32'h00000000);
    go(24'h088007, 23'h002000, 24'h000006, 1'b1, 23'h002004);
    check({28'h0000000, work_reg_sel_q}, 32'h00000007);
    st(3'h1, 1'b1);
    rd(`HWL_ADDR_COUNT, 32'h0000200F);
    rd(`HWL_ADDR_START, 32'h00002004);
    rd(`HWL_ADDR_END, 32'h00002010);
    rd(`HWL_ADDR_CORE_CTL, 32'h00000100);
    rd(`HWL_ADDR_STATUS, 32'h00000080);
    wr(`HWL_ADDR_START, 32'h0000FFFF);
    rd(`HWL_ADDR_START, 32'h00002004);
    // Nested loop, negative offset, count bits all in the top two
    go(24'h088002, 23'h002100, 24'h00FFFD, 1'b1, 23'h002104);
    st(3'h2, 1'b1);
    rd(`HWL_ADDR_COUNT, 32'h00000000);
    rd(`HWL_ADDR_END, 32'h000020FE);
    fet(23'h0020FE, 1'b0, 23'h000000);
    st(3'h1, 1'b1);
    rd(`HWL_ADDR_COUNT, 32'h0000200F);
    rd(`HWL_ADDR_START, 32'h00002004);
    rd(`HWL_ADDR_END, 32'h00002010);
    wr(`HWL_ADDR_COUNT, 32'h00000001);
    fet(23'h002010, 1'b1, 23'h002004);
    fet(23'h002010, 1'b0, 23'h000000);
    st(3'h0, 1'b0);
    // One shadow level: the outer loop gets the outer context back
    rd(`HWL_ADDR_COUNT, 32'h0000200F);
    // Second word with a non-zero top byte drops the pair
    go(24'h088007, 23'h003000, 24'h123456, 1'b0, 23'h000000);
    st(3'h0, 1'b0);
    // Level field stays read-only under a full write
    wr(`HWL_ADDR_CORE_CTL, 32'h0000FFFF);
    rd(`HWL_ADDR_CORE_CTL, 32'h0000F8FF);
    finish_test();
  end

  // Whole sequence needs well under 200 cycles
  initial begin
    #20000;
    mismatches++;
    finish_test();
  end
endmodule
